// ---- common/psf_pkg.sv ----
package psf_pkg;

    // clock and sampling cadence
    localparam int CLOCK_HZ = 250_000_000;
    localparam int PERIOD_MS = 20;
    localparam int PERIOD_CYCLES = CLOCK_HZ / 1000 * PERIOD_MS;
    localparam int BAUD_RATE = 9600;
    localparam int BAUD_CYCLES = CLOCK_HZ / BAUD_RATE;

    // reading width and history buffer depth
    localparam int SAMPLE_W = 24;
    localparam int FIFO_DEPTH = 16;
    typedef logic [SAMPLE_W-1:0] sample_t;

    // smoothing weight limits in percent
    localparam logic [6:0] WEIGHT_MAX = 7'h63;
    localparam logic [6:0] WEIGHT_RST = 7'h5a;
    localparam logic [6:0] PCT_FULL = 7'h64;

    // step threshold is 0.02 percent of span: 2 parts in 10000
    localparam int THR_NUM = 2;
    localparam int THR_DEN = 10000;
    localparam sample_t SPAN_RST = 24'hff_ffff;

    // ascii characters of the serial protocol
    localparam logic [7:0] ADDR_RST = 8'h31;
    localparam logic [7:0] CH_HASH = 8'h23;
    localparam logic [7:0] CH_STAR = 8'h2a;
    localparam logic [7:0] CH_QUERY = 8'h3f;
    localparam logic [7:0] CH_SPACE = 8'h20;
    localparam logic [7:0] CH_CR = 8'h0d;
    localparam logic [7:0] CH_LF = 8'h0a;
    localparam logic [3:0] REPLY_LAST = 4'h9;
    localparam logic [3:0] FRAME_LAST = 4'h9;
    localparam logic [3:0] DATA_LAST = 4'h7;

    // register byte offsets
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_WEIGHT0 = 8'h04;
    localparam logic [7:0] OFF_WEIGHT1 = 8'h08;
    localparam logic [7:0] OFF_ADDR0 = 8'h0c;
    localparam logic [7:0] OFF_ADDR1 = 8'h10;
    localparam logic [7:0] OFF_SPAN0 = 8'h14;
    localparam logic [7:0] OFF_SPAN1 = 8'h18;
    localparam logic [7:0] OFF_STATUS = 8'h1c;
    localparam logic [7:0] OFF_READING = 8'h20;
    localparam logic [7:0] OFF_FIFO = 8'h24;

    // serial receiver and command parser states
    typedef enum logic [3:0] {
        RX_IDLE = 4'b0001,
        RX_START = 4'b0010,
        RX_DATA = 4'b0100,
        RX_STOP = 4'b1000
    } rx_state_t;

    typedef enum logic [2:0] {
        P_HASH = 3'b001,
        P_ADDR = 3'b010,
        P_QUERY = 3'b100
    } parse_t;

endpackage : psf_pkg

// ---- common/sample_fifo_if.sv ----
`timescale 1ns/1ps
`default_nettype none

interface sample_fifo_if #(
    parameter int WIDTH = 24,
    parameter int DEPTH = 16
);
    logic push_valid;
    logic push_ready;
    logic [WIDTH-1:0] push_data;
    logic pop_valid;
    logic pop_ready;
    logic [WIDTH-1:0] pop_data;
    logic [$clog2(DEPTH):0] level;

    modport producer(output push_valid, push_data, pop_ready,
                     input push_ready, pop_valid, pop_data, level);
    modport store(input push_valid, push_data, pop_ready,
                  output push_ready, pop_valid, pop_data, level);
endinterface : sample_fifo_if

`default_nettype wire

// ---- hdl/sample_fifo.sv ----
`timescale 1ns/1ps
`default_nettype none

module sample_fifo #(
    parameter int WIDTH = 24,
    parameter int DEPTH = 16
) (
    // clock and reset
    input wire logic clock,
    input wire logic rst,
    // both sides of the buffer
    sample_fifo_if.store q
);
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] FULL = (AW+1)'(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0] wr;
        logic [AW-1:0] rd;
        logic [AW:0] cnt;
    } fifo_state_t;

    fifo_state_t st_ff;
    fifo_state_t nxt_st;

    // pointer step with wrap for any depth
    function automatic logic [AW-1:0] inc(input logic [AW-1:0] p);
        inc = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
    endfunction : inc

    // honest full and empty flags
    assign q.push_ready = (st_ff.cnt != FULL);
    assign q.pop_valid = (st_ff.cnt != '0);
    assign q.pop_data = st_ff.mem[st_ff.rd];
    assign q.level = st_ff.cnt;

    // store on push, advance on pop, count both
    always_comb begin
        logic do_push;
        logic do_pop;
        do_push = q.push_valid && q.push_ready;
        do_pop = q.pop_ready && q.pop_valid;
        nxt_st = st_ff;
        if (do_push) begin
            nxt_st.mem[st_ff.wr] = q.push_data;
            nxt_st.wr = inc(st_ff.wr);
        end
        if (do_pop) begin
            nxt_st.rd = inc(st_ff.rd);
        end
        if (do_push && !do_pop) begin
            nxt_st.cnt = st_ff.cnt + 1'b1;
        end else if (do_pop && !do_push) begin
            nxt_st.cnt = st_ff.cnt - 1'b1;
        end
    end

    // state register
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

endmodule : sample_fifo

`default_nettype wire

// ---- hdl/pressure_sample_filter.sv ----
`timescale 1ns/1ps
`default_nettype none

module pressure_sample_filter #(
    parameter logic [31:0] PERIOD_CYCLES = 32'(psf_pkg::PERIOD_CYCLES),
    parameter logic [15:0] BAUD_CYCLES = 16'(psf_pkg::BAUD_CYCLES),
    parameter int FIFO_DEPTH = psf_pkg::FIFO_DEPTH
) (
    // clock and reset
    input wire logic clock,
    input wire logic rst,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // converter and serial pins
    input wire logic [23:0] raw_sample,
    input wire logic rx,
    output logic tx,
    // filtered reading
    output logic [23:0] reading
);
    typedef psf_pkg::sample_t sample_t;

    typedef struct packed {
        logic a_wr;
        logic a_rd;
        logic [7:0] a_addr;
        logic [31:0] hrdata;
        logic hready;
        logic range_sel;
        logic [1:0][6:0] weight;
        logic [1:0][7:0] addr;
        logic [1:0][23:0] span;
        logic [31:0] tick_cnt;
        logic tick_pend;
        sample_t raw_m;
        sample_t raw_a;
        sample_t raw_b;
        logic primed;
        logic bypass_last;
        sample_t filt;
        sample_t prev_raw;
        logic rx_m;
        logic rx_a;
        logic rx_b;
        logic rx_lvl;
        psf_pkg::rx_state_t rx_st;
        logic [15:0] rx_cnt;
        logic [3:0] rx_bit;
        logic [7:0] rx_sh;
        logic rx_done;
        psf_pkg::parse_t ps;
        logic tx_busy;
        logic [3:0] tx_idx;
        logic [3:0] tx_bit;
        logic [15:0] tx_cnt;
        logic [9:0] tx_sh;
        logic tx_line;
        logic [7:0] reply_addr;
        sample_t reply_val;
    } state_t;

    state_t st_ff;
    state_t nxt_st;

    sample_fifo_if #(.WIDTH(psf_pkg::SAMPLE_W), .DEPTH(FIFO_DEPTH)) fq();

    sample_fifo #(
        .WIDTH(psf_pkg::SAMPLE_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clock(clock),
        .rst(rst),
        .q(fq.store)
    );

    // character helpers
    function automatic logic [7:0] upcase(input logic [7:0] c);
        upcase = (c >= 8'h61 && c <= 8'h7a) ? c - 8'h20 : c;
    endfunction : upcase

    function automatic logic addr_ok(input logic [7:0] c);
        logic [7:0] u;
        u = upcase(c);
        addr_ok = (u >= 8'h30 && u <= 8'h39) || (u >= 8'h41 && u <= 8'h5a);
    endfunction : addr_ok

    function automatic logic [7:0] hexch(input logic [3:0] n);
        hexch = (n < 4'ha) ? 8'h30 + 8'(n) : 8'h37 + 8'(n);
    endfunction : hexch

    function automatic sample_t absdiff(input sample_t x, input sample_t y);
        absdiff = (x > y) ? x - y : y - x;
    endfunction : absdiff

    function automatic sample_t blend(input sample_t old, input sample_t cur,
                                      input logic [6:0] w);
        logic [31:0] acc;
        acc = 32'(old) * 32'(w) + 32'(cur) * 32'(psf_pkg::PCT_FULL - w);
        blend = 24'(acc / 32'(psf_pkg::PCT_FULL));
    endfunction : blend

    function automatic logic [7:0] reply_char(input logic [3:0] i, input logic [7:0] a,
                                              input sample_t v);
        case (i)
            4'h0: reply_char = a;
            4'h1: reply_char = psf_pkg::CH_SPACE;
            4'h2: reply_char = hexch(v[23:20]);
            4'h3: reply_char = hexch(v[19:16]);
            4'h4: reply_char = hexch(v[15:12]);
            4'h5: reply_char = hexch(v[11:8]);
            4'h6: reply_char = hexch(v[7:4]);
            4'h7: reply_char = hexch(v[3:0]);
            4'h8: reply_char = psf_pkg::CH_CR;
            default: reply_char = psf_pkg::CH_LF;
        endcase
    endfunction : reply_char

    // filter step decision for the active range
    logic [6:0] w_act;
    sample_t thr;
    logic step;
    logic bypass;
    sample_t result;
    logic addr_hit;
    logic start_reply;
    assign w_act = st_ff.weight[st_ff.range_sel];
    assign thr = 24'((32'(st_ff.span[st_ff.range_sel]) * psf_pkg::THR_NUM)
                     / psf_pkg::THR_DEN);
    assign step = st_ff.tick_pend && (st_ff.raw_a == st_ff.raw_b) && fq.push_ready;
    assign bypass = !st_ff.primed || (w_act == '0)
                    || (absdiff(st_ff.raw_b, st_ff.prev_raw) > thr);
    assign result = bypass ? st_ff.raw_b : blend(st_ff.filt, st_ff.raw_b, w_act);
    assign addr_hit = (upcase(st_ff.rx_sh) == st_ff.addr[st_ff.range_sel])
                      || (st_ff.rx_sh == psf_pkg::CH_STAR);
    assign start_reply = st_ff.rx_done && (st_ff.ps == psf_pkg::P_QUERY)
                         && (st_ff.rx_sh == psf_pkg::CH_QUERY) && !st_ff.tx_busy;

    // fifo carries each new reading to the bus
    assign fq.push_valid = step;
    assign fq.push_data = result;
    assign fq.pop_ready = st_ff.a_rd && !st_ff.hready && (st_ff.a_addr == psf_pkg::OFF_FIFO);

    // outputs
    assign hrdata = st_ff.hrdata;
    assign hreadyout = st_ff.hready;
    assign hresp = 1'b0;
    assign tx = st_ff.tx_line;
    assign reading = st_ff.filt;

    // next state of every part of the block
    always_comb begin
        logic [31:0] rdv;
        rdv = '0;
        nxt_st = st_ff;
        nxt_st.rx_done = 1'b0;
        // bus address phase, reads insert one wait state
        if (hsel && htrans[1] && hready && st_ff.hready) begin
            nxt_st.a_addr = haddr[7:0];
            nxt_st.a_wr = hwrite;
            nxt_st.a_rd = !hwrite;
            nxt_st.hready = hwrite;
        end else begin
            nxt_st.a_wr = 1'b0;
            if (st_ff.hready) begin
                nxt_st.a_rd = 1'b0;
            end
        end
        // bus read data
        if (st_ff.a_rd && !st_ff.hready) begin
            case (st_ff.a_addr)
                psf_pkg::OFF_CTRL: rdv = {31'h0, st_ff.range_sel};
                psf_pkg::OFF_WEIGHT0: rdv = {25'h0, st_ff.weight[0]};
                psf_pkg::OFF_WEIGHT1: rdv = {25'h0, st_ff.weight[1]};
                psf_pkg::OFF_ADDR0: rdv = {24'h0, st_ff.addr[0]};
                psf_pkg::OFF_ADDR1: rdv = {24'h0, st_ff.addr[1]};
                psf_pkg::OFF_SPAN0: rdv = {8'h0, st_ff.span[0]};
                psf_pkg::OFF_SPAN1: rdv = {8'h0, st_ff.span[1]};
                psf_pkg::OFF_STATUS: rdv = {16'h0, 3'h0, 5'(fq.level), 4'h0,
                                            st_ff.tx_busy, fq.pop_valid,
                                            st_ff.bypass_last, st_ff.primed};
                psf_pkg::OFF_READING: rdv = {8'h0, st_ff.filt};
                psf_pkg::OFF_FIFO: rdv = fq.pop_valid ? {8'h0, fq.pop_data} : 32'h0;
                default: rdv = '0;
            endcase
            nxt_st.hrdata = rdv;
            nxt_st.hready = 1'b1;
        end
        // bus write data phase
        if (st_ff.a_wr) begin
            case (st_ff.a_addr)
                psf_pkg::OFF_CTRL: nxt_st.range_sel = hwdata[0];
                psf_pkg::OFF_WEIGHT0: begin
                    if (hwdata <= 32'(psf_pkg::WEIGHT_MAX)) nxt_st.weight[0] = hwdata[6:0];
                end
                psf_pkg::OFF_WEIGHT1: begin
                    if (hwdata <= 32'(psf_pkg::WEIGHT_MAX)) nxt_st.weight[1] = hwdata[6:0];
                end
                psf_pkg::OFF_ADDR0: begin
                    if (hwdata[31:8] == '0 && addr_ok(hwdata[7:0])) begin
                        nxt_st.addr[0] = upcase(hwdata[7:0]);
                    end
                end
                psf_pkg::OFF_ADDR1: begin
                    if (hwdata[31:8] == '0 && addr_ok(hwdata[7:0])) begin
                        nxt_st.addr[1] = upcase(hwdata[7:0]);
                    end
                end
                psf_pkg::OFF_SPAN0: nxt_st.span[0] = hwdata[23:0];
                psf_pkg::OFF_SPAN1: nxt_st.span[1] = hwdata[23:0];
                default: ;
            endcase
        end
        // sample period timer, a new tick wins over a consumed one
        nxt_st.raw_m = raw_sample;
        nxt_st.raw_a = st_ff.raw_m;
        nxt_st.raw_b = st_ff.raw_a;
        if (st_ff.tick_cnt == PERIOD_CYCLES - 1'b1) begin
            nxt_st.tick_cnt = '0;
            nxt_st.tick_pend = 1'b1;
        end else begin
            nxt_st.tick_cnt = st_ff.tick_cnt + 1'b1;
            if (step) nxt_st.tick_pend = 1'b0;
        end
        // filter update, history never cleared by a range change
        if (step) begin
            nxt_st.filt = result;
            nxt_st.prev_raw = st_ff.raw_b;
            nxt_st.primed = 1'b1;
            nxt_st.bypass_last = bypass;
        end
        // serial line synchroniser
        nxt_st.rx_m = rx;
        nxt_st.rx_a = st_ff.rx_m;
        nxt_st.rx_b = st_ff.rx_a;
        if (st_ff.rx_a == st_ff.rx_b) nxt_st.rx_lvl = st_ff.rx_b;
        // receiver, 8 data bits, no parity, 1 stop bit
        if (st_ff.rx_cnt != '0) nxt_st.rx_cnt = st_ff.rx_cnt - 1'b1;
        unique case (st_ff.rx_st)
            psf_pkg::RX_IDLE: begin
                if (!st_ff.rx_lvl) begin
                    nxt_st.rx_st = psf_pkg::RX_START;
                    nxt_st.rx_cnt = BAUD_CYCLES >> 1;
                end
            end
            psf_pkg::RX_START: begin
                if (st_ff.rx_cnt == '0) begin
                    nxt_st.rx_st = st_ff.rx_lvl ? psf_pkg::RX_IDLE : psf_pkg::RX_DATA;
                    nxt_st.rx_cnt = BAUD_CYCLES - 1'b1;
                    nxt_st.rx_bit = '0;
                end
            end
            psf_pkg::RX_DATA: begin
                if (st_ff.rx_cnt == '0) begin
                    nxt_st.rx_sh = {st_ff.rx_lvl, st_ff.rx_sh[7:1]};
                    nxt_st.rx_bit = st_ff.rx_bit + 1'b1;
                    nxt_st.rx_cnt = BAUD_CYCLES - 1'b1;
                    if (st_ff.rx_bit == psf_pkg::DATA_LAST) nxt_st.rx_st = psf_pkg::RX_STOP;
                end
            end
            psf_pkg::RX_STOP: begin
                if (st_ff.rx_cnt == '0) begin
                    nxt_st.rx_done = st_ff.rx_lvl;
                    nxt_st.rx_st = psf_pkg::RX_IDLE;
                end
            end
        endcase
        // command parser: hash, address, query
        if (st_ff.rx_done) begin
            if (st_ff.rx_sh == psf_pkg::CH_HASH) begin
                nxt_st.ps = psf_pkg::P_ADDR;
            end else begin
                unique case (st_ff.ps)
                    psf_pkg::P_HASH: nxt_st.ps = psf_pkg::P_HASH;
                    psf_pkg::P_ADDR: nxt_st.ps = addr_hit ? psf_pkg::P_QUERY
                                                          : psf_pkg::P_HASH;
                    psf_pkg::P_QUERY: nxt_st.ps = psf_pkg::P_HASH;
                endcase
            end
        end
        // transmitter, reply frame of ten characters
        if (start_reply) begin
            nxt_st.reply_addr = st_ff.addr[st_ff.range_sel];
            nxt_st.reply_val = st_ff.filt;
            nxt_st.tx_busy = 1'b1;
            nxt_st.tx_idx = '0;
            nxt_st.tx_bit = '0;
            nxt_st.tx_cnt = BAUD_CYCLES - 1'b1;
            nxt_st.tx_sh = {1'b1, st_ff.addr[st_ff.range_sel], 1'b0};
        end else if (st_ff.tx_busy) begin
            if (st_ff.tx_cnt != '0) begin
                nxt_st.tx_cnt = st_ff.tx_cnt - 1'b1;
            end else if (st_ff.tx_bit != psf_pkg::FRAME_LAST) begin
                nxt_st.tx_bit = st_ff.tx_bit + 1'b1;
                nxt_st.tx_sh = {1'b1, st_ff.tx_sh[9:1]};
                nxt_st.tx_cnt = BAUD_CYCLES - 1'b1;
            end else if (st_ff.tx_idx == psf_pkg::REPLY_LAST) begin
                nxt_st.tx_busy = 1'b0;
            end else begin
                nxt_st.tx_idx = st_ff.tx_idx + 1'b1;
                nxt_st.tx_bit = '0;
                nxt_st.tx_cnt = BAUD_CYCLES - 1'b1;
                nxt_st.tx_sh = {1'b1, reply_char(st_ff.tx_idx + 1'b1, st_ff.reply_addr,
                                                 st_ff.reply_val), 1'b0};
            end
        end
        nxt_st.tx_line = nxt_st.tx_busy ? nxt_st.tx_sh[0] : 1'b1;
    end

    // state register with defined reset values
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            st_ff <= '0;
            st_ff.hready <= 1'b1;
            st_ff.weight <= {psf_pkg::WEIGHT_RST, psf_pkg::WEIGHT_RST};
            st_ff.addr <= {psf_pkg::ADDR_RST, psf_pkg::ADDR_RST};
            st_ff.span <= {psf_pkg::SPAN_RST, psf_pkg::SPAN_RST};
            st_ff.raw_m <= '0;
            st_ff.rx_m <= 1'b1;
            st_ff.rx_a <= 1'b1;
            st_ff.rx_b <= 1'b1;
            st_ff.rx_lvl <= 1'b1;
            st_ff.rx_st <= psf_pkg::RX_IDLE;
            st_ff.ps <= psf_pkg::P_HASH;
            st_ff.tx_line <= 1'b1;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // checks on the block's own behaviour
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    sequence query_done_s;
        st_ff.rx_done && st_ff.ps == psf_pkg::P_QUERY && st_ff.rx_sh == psf_pkg::CH_QUERY;
    endsequence
    sequence reply_open_s;
        st_ff.tx_busy && st_ff.tx_idx == 4'h0 && st_ff.tx_line == 1'b0;
    endsequence

    tick_period_a: assert property (
        st_ff.tick_cnt == PERIOD_CYCLES - 1'b1 |=> st_ff.tick_pend && st_ff.tick_cnt == '0)
        else $error("sample tick missed its period");
    weight_range_a: assert property (
        st_ff.weight[0] <= psf_pkg::WEIGHT_MAX && st_ff.weight[1] <= psf_pkg::WEIGHT_MAX)
        else $error("weight above limit");
    big_step_a: assert property (
        step && w_act != '0 && absdiff(st_ff.raw_b, st_ff.prev_raw) > thr
        |=> st_ff.bypass_last && st_ff.filt == $past(st_ff.raw_b))
        else $error("large step was smoothed");
    blend_out_a: assert property (
        step && !bypass |=> st_ff.filt == $past(blend(st_ff.filt, st_ff.raw_b, w_act)))
        else $error("blend result wrong");
    history_load_a: assert property (
        step && bypass |=> st_ff.prev_raw == st_ff.filt && fq.level != '0)
        else $error("bypass did not load history");
    range_keep_a: assert property (
        $changed(st_ff.range_sel) && !$past(step) |-> $stable(st_ff.filt))
        else $error("range switch touched history");
    quiet_other_a: assert property (
        st_ff.rx_done && st_ff.ps == psf_pkg::P_ADDR && st_ff.rx_sh != psf_pkg::CH_HASH
        && !addr_hit |=> st_ff.ps == psf_pkg::P_HASH)
        else $error("foreign address not ignored");
    reply_head_a: assert property (
        query_done_s ##0 !st_ff.tx_busy |=> reply_open_s ##0
        st_ff.tx_sh[8:1] == $past(st_ff.addr[st_ff.range_sel]))
        else $error("reply did not open with active address");
    first_load_a: assert property (
        step && !st_ff.primed |=> st_ff.primed && st_ff.filt == $past(st_ff.raw_b))
        else $error("first sample not loaded directly");

endmodule : pressure_sample_filter

`default_nettype wire

// ---- verif/serial_host_model.sv ----
`timescale 1ns/1ps
`default_nettype none

module serial_host_model #(
    parameter int BIT = 16
) (
    // serial pins seen from the host
    input wire logic clock,
    output logic rx,
    input wire logic tx
);
    // single unit on this line, so its address is unique
    logic [7:0] got[$];
    logic [7:0] c;
    initial rx = 1'b1;
    // one frame: start, 8 data lsb first, stop, idle high
    task automatic send(input logic [7:0] d);
        logic [9:0] f;
        f = {1'b1, d, 1'b0};
        for (int i = 0; i < 10; i++) begin
            @(posedge clock);
            rx <= f[i];
            repeat (BIT - 1) @(posedge clock);
        end
    endtask : send
    // capture reply characters at mid bit
    always begin
        @(negedge tx);
        repeat (BIT / 2 + BIT) @(posedge clock);
        for (int i = 0; i < 8; i++) begin
            c[i] = tx;
            repeat (BIT) @(posedge clock);
        end
        got.push_back(c);
    end
endmodule : serial_host_model

`default_nettype wire

// ---- verif/tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none

module tb_top;
    logic clock, rst, hsel, hwrite, hreadyout, hresp, rx, tx;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [31:0] haddr, hwdata, hrdata, r;
    logic [23:0] raw_sample, reading;
    int fail_count, comparisons, n;
    string e;
    // short sampling period and bit time
    pressure_sample_filter #(.PERIOD_CYCLES(32'h0000_00c8), .BAUD_CYCLES(16'h0010))
        u_dut(.clock(clock), .rst(rst), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .raw_sample(raw_sample),
        .rx(rx), .tx(tx), .reading(reading));
    serial_host_model #(.BIT(16)) u_host(.clock(clock), .rx(rx), .tx(tx));
    // free running clock
    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end
    // verdict
    task automatic end_sim();
        $display("mismatches %0d comparisons %0d", fail_count, comparisons);
        if (fail_count == 0 && comparisons > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : end_sim
    // compare one value
    task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
        comparisons++;
        if (g !== x) begin
            fail_count++;
            $display("Error %s expected %h seen %h", nm, x, g);
        end
    endtask : chk
    // one ahb single transfer; hready sampled at each rising edge
    task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h00_0000, a};
        hwrite <= w;
        do @(posedge clock); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= d;
        do @(posedge clock); while (hreadyout !== 1'b1);
        r = hrdata;
    endtask : ahb
    task automatic rd(input logic [7:0] a);
        ahb(1'b0, a, 32'h0000_0000);
    endtask : rd
    // change raw input, then wait for the next reading change
    task automatic step(input logic [23:0] v, input logic [23:0] x);
        logic [23:0] o;
        @(posedge clock);
        raw_sample <= v;
        @(negedge clock);
        o = reading;
        n = 0;
        while (reading === o && n < 1000) begin
            @(negedge clock);
            n++;
        end
        chk("reading", {8'h00, x}, {8'h00, reading});
    endtask : step
    // send one query and let the reply finish
    task automatic ask(input logic [7:0] a);
        u_host.got.delete();
        u_host.send(8'h23);
        u_host.send(a);
        u_host.send(8'h3f);
        repeat (2000) @(posedge clock);
    endtask : ask
    // watchdog
    initial begin
        #200000;
        fail_count++;
        end_sim();
    end
    // main sequence
    initial begin
        rst = 1'b1;
        {hsel, hwrite, htrans, haddr, hwdata} = '0;
        hsize = 3'h2;
        raw_sample = 24'h0003e8;
        repeat (2) @(posedge clock);
        rst <= 1'b0;
        rd(psf_pkg::OFF_WEIGHT0); chk("weight0", 32'h5a, r);
        chk("hresp", 32'h0, {31'h0, hresp});
        rd(psf_pkg::OFF_WEIGHT1); chk("weight1", 32'h5a, r);
        rd(psf_pkg::OFF_ADDR0); chk("addr0", 32'h31, r);
        rd(8'h30); chk("unmapped", 32'h0, r);
        ahb(1'b1, psf_pkg::OFF_WEIGHT0, 32'h64);
        rd(psf_pkg::OFF_WEIGHT0); chk("weight over", 32'h5a, r);
        repeat (4400) @(posedge clock);
        rd(psf_pkg::OFF_STATUS); chk("full", 32'h1004, r & 32'h1f04);
        // the stalled tick refills one slot after the first pop
        for (int i = 0; i < 17; i++) begin
            rd(psf_pkg::OFF_FIFO); chk("fifo", 32'h3e8, r);
        end
        rd(psf_pkg::OFF_FIFO); chk("fifo empty", 32'h0, r);
        step(24'd1100, 24'd1010);
        step(24'd1100, 24'd1019);
        // one cycle passes before the task starts counting
        chk("period", 32'd200, n + 1);
        step(24'd20000, 24'd20000);
        step(24'd16000, 24'd16000);
        step(24'd19355, 24'd16335);
        ahb(1'b1, psf_pkg::OFF_WEIGHT0, 32'h0);
        step(24'd19365, 24'd19365);
        ahb(1'b1, psf_pkg::OFF_WEIGHT1, 32'h32);
        ahb(1'b1, psf_pkg::OFF_CTRL, 32'h1);
        step(24'd19465, 24'd19415);
        ahb(1'b1, psf_pkg::OFF_WEIGHT1, 32'h0);
        ahb(1'b1, psf_pkg::OFF_ADDR1, 32'h62);
        rd(psf_pkg::OFF_ADDR1); chk("addr1", 32'h42, r);
        repeat (500) @(posedge clock);
        rd(psf_pkg::OFF_READING); chk("settled", 32'd19465, r);
        ask(8'h31); chk("silent", 32'd0, u_host.got.size());
        ask(8'h2a); chk("reply len", 32'd10, u_host.got.size());
        e = "B 004C09\r\n";
        for (int i = 0; i < 10; i++) begin
            chk("reply char", {24'h0, e[i]}, {24'h0, u_host.got[i]});
        end
        ask(8'h62); chk("case blind", 32'h42, {24'h0, u_host.got[0]});
        end_sim();
    end
endmodule : tb_top

`default_nettype wire
